/* File: rtl/buf_geometry.sv */
// dword counts of one transmit buffer from its offset, size and end alignment
`timescale 1ns/1ps
`include "tx_unpack_defs.svh"
module buf_geometry
  import tx_unpack_pkg::*;
(
  geom_if.calc g // command fields in, dword counts out
);
  // ****************************************
  // geometry
  // ****************************************
  logic [11:0] span_bytes;
  dw_cnt_t total_dw;
  dw_cnt_t align_mask;
  assign span_bytes = {10'h000, g.offset[1:0]} + {1'b0, g.size} + `CNT_ROUND;
  assign g.skip_dw = {9'h000, g.offset[4:2]};
  assign g.data_dw = (g.size == 11'h000) ? `CNT_ZERO : {2'h0, span_bytes[11:2]};
  assign total_dw = g.skip_dw + g.data_dw;
  assign align_mask = (g.align == `ALIGN_16) ? `MASK_16 :
    (g.align == `ALIGN_32) ? `MASK_32 : `MASK_4;
  assign g.pad_dw = (`CNT_ZERO - total_dw) & align_mask;
  assign g.last_lane = g.offset[1:0] + g.size[1:0] - `LANE_STEP;
endmodule : buf_geometry

/* File: rtl/lane_unpacker.sv */
// walks the valid byte lanes of one payload dword out to the mac side
`timescale 1ns/1ps
`include "tx_unpack_defs.svh"
module lane_unpacker
  import tx_unpack_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  lane_if.unpack u // dword in, bytes out
);
  // ****************************************
  // lane walk
  // ****************************************
  logic [31:0] word;
  logic [1:0] lane;
  logic [1:0] stop;
  logic eop;
  logic valid;
  logic [7:0] bdata;
  logic blast;
  logic drained;
  logic advance;
  logic [31:0] src_word;
  logic [1:0] next_lane;
  logic [1:0] src_stop;
  logic src_eop;
  assign drained = valid & u.byte_ready & (lane == stop);
  assign advance = valid & u.byte_ready & (lane != stop);
  assign src_word = u.load ? u.word : word;
  assign next_lane = u.load ? u.first_lane : lane + `LANE_STEP;
  assign src_stop = u.load ? u.last_lane : stop;
  assign src_eop = u.load ? u.eop : eop;
  assign u.idle_next = ~u.load & (~valid | drained);
  assign u.byte_data = bdata;
  assign u.byte_valid = valid;
  assign u.byte_last = blast;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      word <= 32'h0000_0000;
      lane <= `LANE_FIRST;
      stop <= `LANE_FIRST;
      eop <= 1'b0;
      bdata <= 8'h00;
      blast <= 1'b0;
      valid <= 1'b0;
    end else begin
      if (u.load | advance) begin
        word <= src_word;
        lane <= next_lane;
        stop <= src_stop;
        eop <= src_eop;
        bdata <= src_word[{next_lane, 3'h0} +: 8];
        blast <= (next_lane == src_stop) & src_eop;
      end
      valid <= u.load | (valid & ~drained);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_byte_held_stall:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      valid && !u.byte_ready |=> valid && $stable(bdata) && $stable(blast))
    else $error("byte changed while stalled");
  a_load_when_free:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      u.load |-> !valid || drained)
    else $error("dword loaded over a busy lane walk");
endmodule : lane_unpacker

/* File: rtl/tx_command_buffer_unpacker.sv */
// parses transmit buffers and forwards their payload bytes to the mac side
`timescale 1ns/1ps
`include "tx_unpack_defs.svh"
// Summary of operation
// - read 11-bit buffer size from the first command word.
// - derive trailing padding dwords from buffer offset, size and end alignment.
// - sum buffer sizes per packet; flag error if unequal to packet length.
// - copy the tag into the packet's status output.
// - request checksum only with request bit, first segment and engine enabled.
// - crc-disable bit suppresses the automatic crc unless pad-disable is set.
// - pad-disable stops short-frame padding and forces crc append.
// - second word's 11-bit length is the packet's total byte count.
// - payload starts after the command words.
// - low offset bits pick the first valid byte lane.
// - upper offset bits skip up to seven leading dwords.
// - payload is contiguous; unused trailing bytes are not forwarded.
// - end padding is discarded, never forwarded.
// - second command word comes only with first segment; expected only then.
module tx_command_buffer_unpacker
  import tx_unpack_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic [31:0] i_fifo_data, // transmit data fifo dword
  input wire logic i_fifo_valid, // dword present
  input wire logic i_fifo_first, // dword is a first command word
  output logic o_fifo_ready, // dword taken when valid and ready
  output logic [7:0] o_mil_data, // payload byte to mac interface layer
  output logic o_mil_valid, // payload byte present
  output logic o_mil_last, // last byte of the packet
  input wire logic i_mil_ready, // mac interface layer takes the byte
  input wire logic i_tx_checksum_engine_on, // checksum engine enable
  input wire logic i_err_clear, // clears the error flag
  output logic o_transmitter_error_flag, // sticky transmit error
  output logic o_pkt_valid, // one-cycle pulse: packet controls new
  output logic [15:0] o_pkt_tag, // tag for the packet status word
  output logic o_tx_checksum_request, // compute layer-3 checksum
  output logic o_crc_append, // append frame crc
  output logic o_pad_enable, // pad short frames
  output logic [10:0] o_pkt_length // declared packet length
);
  // ****************************************
  // state
  // ****************************************
  unpack_state_e state;
  unpack_state_e next_state;
  dw_cnt_t cnt;
  dw_cnt_t next_cnt;
  dw_cnt_t skip_r;
  dw_cnt_t data_dw_r;
  dw_cnt_t pad_dw_r;
  logic fs_r;
  logic ls_r;
  logic [1:0] off_lo_r;
  logic [1:0] last_lane_r;
  logic first_dw;
  logic pkt_open;
  len_sum_t sum_r;
  logic [10:0] pkt_len_r;
  logic next_ready;
  logic next_err;

  geom_if g ();
  lane_if u ();

  buf_geometry geom (
    .g (g.calc)
  );

  lane_unpacker lanes (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .u (u.unpack)
  );

  // ****************************************
  // decode
  // ****************************************
  logic accept;
  logic in_body;
  logic intrude;
  logic take_a;
  logic junk_a;
  logic take_b;
  logic data_take;
  logic a_fs;
  logic a_ls;
  logic [10:0] a_size;
  logic [10:0] b_len;
  len_sum_t a_sum;
  logic mismatch_a;
  logic mismatch_b;
  logic seq_err;
  logic set_err;
  logic cnt_last;
  dw_cnt_t h_skip;
  dw_cnt_t h_data;
  dw_cnt_t h_pad;
  unpack_state_e h_state;
  dw_cnt_t h_cnt;
  unpack_state_e post_skip;
  unpack_state_e post_data;

  assign accept = i_fifo_valid & o_fifo_ready;
  assign in_body = (state == ST_SKIP) | (state == ST_DATA) | (state == ST_PAD);
  assign intrude = accept & i_fifo_first & in_body;
  assign take_a = (accept & (state == ST_CMD_A) & i_fifo_first) | intrude;
  assign junk_a = accept & (state == ST_CMD_A) & ~i_fifo_first;
  assign take_b = accept & (state == ST_CMD_B);
  assign data_take = accept & (state == ST_DATA) & ~i_fifo_first;
  assign a_fs = i_fifo_data[`TXA_FS_BIT];
  assign a_ls = i_fifo_data[`TXA_LS_BIT];
  assign a_size = i_fifo_data[`TXA_SIZE_MSB:0];
  assign b_len = i_fifo_data[`TXB_LEN_MSB:0];
  assign a_sum = a_fs ? {5'h00, a_size} : sum_r + {5'h00, a_size};
  assign mismatch_a = take_a & ~a_fs & a_ls & (a_sum != {5'h00, pkt_len_r});
  assign mismatch_b = take_b & ls_r & (sum_r != {5'h00, b_len});
  assign seq_err = take_a & (a_fs == pkt_open);
  assign set_err = mismatch_a | mismatch_b | seq_err | intrude | junk_a;
  assign next_err = set_err | (o_transmitter_error_flag & ~i_err_clear);

  assign g.offset = i_fifo_data[`TXA_OFF_MSB:`TXA_OFF_LSB];
  assign g.size = a_size;
  assign g.align = i_fifo_data[`TXA_ALIGN_MSB:`TXA_ALIGN_LSB];

  // ****************************************
  // phase selection
  // ****************************************
  assign cnt_last = (cnt == `CNT_ONE);
  assign h_skip = take_a ? g.skip_dw : skip_r;
  assign h_data = take_a ? g.data_dw : data_dw_r;
  assign h_pad = take_a ? g.pad_dw : pad_dw_r;
  assign h_state = (h_skip != `CNT_ZERO) ? ST_SKIP :
    (h_data != `CNT_ZERO) ? ST_DATA :
    (h_pad != `CNT_ZERO) ? ST_PAD : ST_CMD_A;
  assign h_cnt = (h_skip != `CNT_ZERO) ? h_skip :
    (h_data != `CNT_ZERO) ? h_data : h_pad;
  assign post_skip = (data_dw_r != `CNT_ZERO) ? ST_DATA :
    (pad_dw_r != `CNT_ZERO) ? ST_PAD : ST_CMD_A;
  assign post_data = (pad_dw_r != `CNT_ZERO) ? ST_PAD : ST_CMD_A;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (take_a) begin
      if (a_fs) begin
        next_state = ST_CMD_B;
      end else begin
        next_state = h_state;
        next_cnt = h_cnt;
      end
    end else begin
      unique case (state)
        ST_CMD_A: begin
          next_state = ST_CMD_A;
        end
        ST_CMD_B: begin
          if (take_b) begin
            next_state = h_state;
            next_cnt = h_cnt;
          end
        end
        ST_SKIP: begin
          if (accept) begin
            next_state = cnt_last ? post_skip : ST_SKIP;
            next_cnt = cnt_last ? ((post_skip == ST_DATA) ? data_dw_r : pad_dw_r)
              : cnt - `CNT_ONE;
          end
        end
        ST_DATA: begin
          if (data_take) begin
            next_state = cnt_last ? post_data : ST_DATA;
            next_cnt = cnt_last ? pad_dw_r : cnt - `CNT_ONE;
          end
        end
        ST_PAD: begin
          if (accept) begin
            next_state = cnt_last ? ST_CMD_A : ST_PAD;
            next_cnt = cnt - `CNT_ONE;
          end
        end
        default: begin
          next_state = ST_CMD_A;
        end
      endcase
    end
  end

  // ****************************************
  // lane feed and flow control
  // ****************************************
  assign u.load = data_take;
  assign u.word = i_fifo_data;
  assign u.first_lane = first_dw ? off_lo_r : `LANE_FIRST;
  assign u.last_lane = cnt_last ? last_lane_r : `LANE_LAST;
  assign u.eop = cnt_last & ls_r;
  assign u.byte_ready = i_mil_ready;
  assign next_ready = (next_state != ST_DATA) | u.idle_next;
  assign o_mil_data = u.byte_data;
  assign o_mil_valid = u.byte_valid;
  assign o_mil_last = u.byte_last;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state <= ST_CMD_A;
      cnt <= `CNT_ZERO;
      o_fifo_ready <= 1'b0;
      o_transmitter_error_flag <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      o_fifo_ready <= next_ready;
      o_transmitter_error_flag <= next_err;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      skip_r <= `CNT_ZERO;
      data_dw_r <= `CNT_ZERO;
      pad_dw_r <= `CNT_ZERO;
      fs_r <= 1'b0;
      ls_r <= 1'b0;
      off_lo_r <= `LANE_FIRST;
      last_lane_r <= `LANE_FIRST;
      pkt_open <= 1'b0;
      sum_r <= 16'h0000;
    end else if (take_a) begin
      skip_r <= g.skip_dw;
      data_dw_r <= g.data_dw;
      pad_dw_r <= g.pad_dw;
      fs_r <= a_fs;
      ls_r <= a_ls;
      off_lo_r <= g.offset[1:0];
      last_lane_r <= g.last_lane;
      pkt_open <= ~a_ls;
      sum_r <= a_sum;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      first_dw <= 1'b0;
    end else begin
      first_dw <= take_a | (first_dw & ~data_take);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pkt_valid <= 1'b0;
      o_pkt_tag <= 16'h0000;
      o_tx_checksum_request <= 1'b0;
      o_crc_append <= 1'b0;
      o_pad_enable <= 1'b0;
      o_pkt_length <= 11'h000;
      pkt_len_r <= 11'h000;
    end else begin
      o_pkt_valid <= take_b;
      if (take_b) begin
        o_pkt_tag <= i_fifo_data[`TXB_TAG_MSB:`TXB_TAG_LSB];
        o_tx_checksum_request <= i_fifo_data[`TXB_CK_BIT] & fs_r
          & i_tx_checksum_engine_on;
        o_crc_append <= ~i_fifo_data[`TXB_CRCDIS_BIT]
          | i_fifo_data[`TXB_PADDIS_BIT];
        o_pad_enable <= ~i_fifo_data[`TXB_PADDIS_BIT];
        o_pkt_length <= b_len;
        pkt_len_r <= b_len;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_length_mismatch_err:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take_b && ls_r && (sum_r != {5'h00, b_len}) |=> o_transmitter_error_flag)
    else $error("length mismatch not flagged");
  a_error_flag_sticky:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_transmitter_error_flag && !i_err_clear |=> o_transmitter_error_flag)
    else $error("error flag dropped without clear");
  a_tag_copied_out:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take_b |=> o_pkt_valid && o_pkt_tag == $past(i_fifo_data[31:16]))
    else $error("tag not copied");
  a_checksum_gated:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_pkt_valid && o_tx_checksum_request |->
        $past(i_tx_checksum_engine_on) && $past(i_fifo_data[14]) && $past(fs_r))
    else $error("checksum requested without all conditions");
  a_crc_pad_ctrl:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_pkt_valid |-> o_pad_enable == !$past(i_fifo_data[12])
        && o_crc_append == (!$past(i_fifo_data[13]) || $past(i_fifo_data[12])))
    else $error("crc or pad control wrong");
  a_second_word_fs:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take_a |=> (state == ST_CMD_B) == $past(a_fs))
    else $error("second command word expectation wrong");
  a_skip_counted:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take_a && !a_fs && i_fifo_data[20:18] != 3'h0 |=>
        state == ST_SKIP && cnt == {9'h000, $past(i_fifo_data[20:18])})
    else $error("leading dword skip wrong");
  a_pad_not_sent:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      state == ST_PAD || state == ST_SKIP |-> !u.load)
    else $error("padding or skipped dword forwarded");
  a_first_lane_sel:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      u.load && first_dw |=> o_mil_data == $past(i_fifo_data[{off_lo_r, 3'h0} +: 8]))
    else $error("first byte lane wrong");
  a_intrusion_flagged:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      accept && i_fifo_first && in_body |=>
        o_transmitter_error_flag && first_dw)
    else $error("command word inside data not flagged");
endmodule : tx_command_buffer_unpacker

/* File: rtl/tx_unpack_defs.svh */
// field positions, encodings and constants of the transmit buffer unpacker
`ifndef TX_UNPACK_DEFS_SVH
`define TX_UNPACK_DEFS_SVH
`define TXA_ALIGN_MSB 25
`define TXA_ALIGN_LSB 24
`define TXA_OFF_MSB 20
`define TXA_OFF_LSB 16
`define TXA_FS_BIT 13
`define TXA_LS_BIT 12
`define TXA_SIZE_MSB 10
`define TXB_TAG_MSB 31
`define TXB_TAG_LSB 16
`define TXB_CK_BIT 14
`define TXB_CRCDIS_BIT 13
`define TXB_PADDIS_BIT 12
`define TXB_LEN_MSB 10
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define MASK_4 12'h000
`define MASK_16 12'h003
`define MASK_32 12'h007
`define LANE_FIRST 2'h0
`define LANE_LAST 2'h3
`define LANE_STEP 2'h1
`define CNT_ZERO 12'h000
`define CNT_ONE 12'h001
`define CNT_ROUND 12'h003
`endif

/* File: rtl/tx_unpack_if.sv */
// interfaces between the unpacker and its geometry and lane helpers
`timescale 1ns/1ps
interface geom_if;
  import tx_unpack_pkg::*;
  logic [4:0] offset;
  logic [10:0] size;
  logic [1:0] align;
  dw_cnt_t skip_dw;
  dw_cnt_t data_dw;
  dw_cnt_t pad_dw;
  logic [1:0] last_lane;
  modport calc (input offset, size, align, output skip_dw, data_dw, pad_dw, last_lane);
  modport user (output offset, size, align, input skip_dw, data_dw, pad_dw, last_lane);
endinterface : geom_if

interface lane_if;
  logic load;
  logic [31:0] word;
  logic [1:0] first_lane;
  logic [1:0] last_lane;
  logic eop;
  logic idle_next;
  logic [7:0] byte_data;
  logic byte_valid;
  logic byte_last;
  logic byte_ready;
  modport unpack (input load, word, first_lane, last_lane, eop, byte_ready,
    output idle_next, byte_data, byte_valid, byte_last);
  modport feed (output load, word, first_lane, last_lane, eop, byte_ready,
    input idle_next, byte_data, byte_valid, byte_last);
endinterface : lane_if

/* File: rtl/tx_unpack_pkg.sv */
// types shared by the transmit buffer unpacker
package tx_unpack_pkg;
  typedef enum logic [2:0] {
    ST_CMD_A = 3'h0,
    ST_CMD_B = 3'h1,
    ST_SKIP = 3'h3,
    ST_DATA = 3'h2,
    ST_PAD = 3'h6
  } unpack_state_e;
  typedef logic [11:0] dw_cnt_t;
  typedef logic [15:0] len_sum_t;
endpackage : tx_unpack_pkg

/* File: sim/host_buffer_model.sv */
// host model that writes transmit buffers into the unpacker fifo port
`timescale 1ns/1ps
module host_buffer_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_fifo_ready, // unpacker takes the dword
  output logic [31:0] o_fifo_data, // dword to the fifo port
  output logic o_fifo_valid, // dword present
  output logic o_fifo_first // dword is a first command word
);
  logic [31:0] word_q[$];
  logic first_q[$];
  int last_q[$];
  int sent_bytes = 0;
  int fs_count = 0;
  int gap = 0;
  int hold = 0;
  logic took = 1'b0;
  initial begin
    o_fifo_data = 32'h0000_0000;
    o_fifo_valid = 1'b0;
    o_fifo_first = 1'b0;
  end
  always @(posedge i_clk_sys) took <= o_fifo_valid & i_fifo_ready;
  // ****************************************
  // port driver: holds each dword until taken
  // ****************************************
  always @(negedge i_clk_sys) begin
    if ((took ? gap == 0 : (!o_fifo_valid && hold == 0)) && word_q.size() > 0) begin
      o_fifo_data <= word_q.pop_front();
      o_fifo_first <= first_q.pop_front();
      o_fifo_valid <= 1'b1;
    end else if (took) begin
      o_fifo_valid <= 1'b0;
      o_fifo_first <= 1'b0;
      o_fifo_data <= ~o_fifo_data; // released bus shows no stale value
      hold <= gap;
    end else if (!o_fifo_valid && hold > 0) begin
      hold <= hold - 1;
    end
  end
  // ****************************************
  // buffer builder
  // ****************************************
  task automatic buffer(input logic fs, input logic ls, input logic [10:0] size,
      input logic [4:0] off, input logic [1:0] align, input logic [15:0] tag,
      input logic [2:0] ctl, input logic [10:0] len, input logic trunc);
    int dws;
    int pad;
    int n;
    int p;
    logic [31:0] w;
    word_q.push_back({6'h00, align, 3'h0, off, 2'h0, fs, ls, 1'b0, size});
    first_q.push_back(1'b1);
    if (fs) begin
      word_q.push_back({tag, 1'b0, ctl, 1'b0, len});
      first_q.push_back(1'b0);
      fs_count++;
    end
    dws = (off[1:0] + size + 3) / 4;
    n = (align == 2'h1) ? 4 : ((align == 2'h2) ? 8 : 1);
    pad = (n - ((off[4:2] + dws) % n)) % n;
    if (trunc) begin
      dws = 0;
      pad = 0;
    end
    for (int k = 0; k < off[4:2] + dws + pad; k++) begin
      w = 32'hC3C3_C3C3 ^ k;
      if (k >= off[4:2] && k < off[4:2] + dws) begin
        for (int b = 0; b < 4; b++) begin
          p = (k - off[4:2]) * 4 + b;
          if (p >= off[1:0] && p < off[1:0] + size) begin
            w[b*8 +: 8] = sent_bytes[7:0];
            sent_bytes++;
          end
        end
      end
      word_q.push_back(w);
      first_q.push_back(1'b0);
    end
    if (ls && size != 11'h000 && !trunc) last_q.push_back(sent_bytes - 1);
  endtask : buffer
endmodule : host_buffer_model

/* File: sim/testbench.sv */
// self-checking bench of the transmit buffer unpacker
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
module testbench;
  import tx_unpack_pkg::*;
  logic i_clk_sys;
  logic i_sys_rst;
  logic [31:0] i_fifo_data;
  logic i_fifo_valid;
  logic i_fifo_first;
  logic o_fifo_ready;
  logic [7:0] o_mil_data;
  logic o_mil_valid;
  logic o_mil_last;
  logic i_mil_ready;
  logic i_tx_checksum_engine_on;
  logic i_err_clear;
  logic o_transmitter_error_flag;
  logic o_pkt_valid;
  logic [15:0] o_pkt_tag;
  logic o_tx_checksum_request;
  logic o_crc_append;
  logic o_pad_enable;
  logic [10:0] o_pkt_length;
  int err_total = 0;
  int comparisons = 0;
  int got_bytes = 0;
  int pkt_pulses = 0;
  int cyc = 0;
  logic stall_on = 1'b0;
  logic exp_last;
  host_buffer_model u_host (.i_clk_sys(i_clk_sys), .i_fifo_ready(o_fifo_ready),
    .o_fifo_data(i_fifo_data), .o_fifo_valid(i_fifo_valid), .o_fifo_first(i_fifo_first));
  tx_command_buffer_unpacker u_tx_command_buffer_unpacker (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_fifo_data(i_fifo_data), .i_fifo_valid(i_fifo_valid),
    .i_fifo_first(i_fifo_first), .o_fifo_ready(o_fifo_ready), .o_mil_data(o_mil_data),
    .o_mil_valid(o_mil_valid), .o_mil_last(o_mil_last), .i_mil_ready(i_mil_ready),
    .i_tx_checksum_engine_on(i_tx_checksum_engine_on), .i_err_clear(i_err_clear),
    .o_transmitter_error_flag(o_transmitter_error_flag), .o_pkt_valid(o_pkt_valid),
    .o_pkt_tag(o_pkt_tag), .o_tx_checksum_request(o_tx_checksum_request),
    .o_crc_append(o_crc_append), .o_pad_enable(o_pad_enable), .o_pkt_length(o_pkt_length));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // ****************************************
  // mac side: stalling sink and byte checker
  // ****************************************
  always @(negedge i_clk_sys) begin
    cyc++;
    i_mil_ready <= stall_on ? (cyc % 3 != 2) : 1'b1;
  end
  always @(posedge i_clk_sys) begin
    if (!i_sys_rst && o_pkt_valid === 1'b1) pkt_pulses++;
    if (!i_sys_rst && o_mil_valid === 1'b1 && i_mil_ready) begin
      exp_last = u_host.last_q.size() > 0 && u_host.last_q[0] == got_bytes;
      if (exp_last) void'(u_host.last_q.pop_front());
      `CHK("mil byte", got_bytes[7:0], o_mil_data)
      `CHK("mil last", exp_last, o_mil_last)
      got_bytes++;
    end
  end
  task automatic settle();
    int n;
    n = 0;
    while ((u_host.word_q.size() != 0 || i_fifo_valid || got_bytes != u_host.sent_bytes)
        && n < 3000) begin
      @(negedge i_clk_sys);
      n++;
    end
    repeat (6) @(negedge i_clk_sys);
    `CHK("drain", 1'b1, n < 3000)
  endtask : settle
  task automatic clear_err();
    i_err_clear = 1'b1;
    @(negedge i_clk_sys);
    i_err_clear = 1'b0;
    @(negedge i_clk_sys);
    `CHK("error cleared", 1'b0, o_transmitter_error_flag)
  endtask : clear_err
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_total++;
    give_verdict();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    i_sys_rst = 1'b1;
    i_mil_ready = 1'b1;
    i_tx_checksum_engine_on = 1'b1;
    i_err_clear = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    stall_on = 1'b1;
    u_host.buffer(1'b1, 1'b1, 11'h005, 5'h01, 2'h0, 16'hA1B2, 3'h0, 11'h005, 1'b0);
    settle();
    `CHK("tag", 16'hA1B2, o_pkt_tag)
    `CHK("length", 11'h005, o_pkt_length)
    `CHK("error", 1'b0, o_transmitter_error_flag)
    for (int i = 0; i < 12; i++) begin
      u_host.buffer(1'b1, 1'b1, 11'(i * 3 + 1), 5'((i * 7) % 32), 2'(i % 3), 16'(i),
        3'h0, 11'(i * 3 + 1), 1'b0);
    end
    settle();
    `CHK("error", 1'b0, o_transmitter_error_flag)
    `CHK("length", 11'h022, o_pkt_length)
    u_host.gap = 2;
    u_host.buffer(1'b1, 1'b0, 11'h003, 5'h02, 2'h0, 16'h1234, 3'h0, 11'h00D, 1'b0);
    u_host.buffer(1'b0, 1'b0, 11'h004, 5'h03, 2'h1, 16'h0000, 3'h0, 11'h000, 1'b0);
    u_host.buffer(1'b0, 1'b1, 11'h006, 5'h00, 2'h2, 16'h0000, 3'h0, 11'h000, 1'b0);
    settle();
    `CHK("error", 1'b0, o_transmitter_error_flag)
    u_host.gap = 0;
    u_host.buffer(1'b1, 1'b0, 11'h003, 5'h00, 2'h0, 16'h5678, 3'h0, 11'h00C, 1'b0);
    u_host.buffer(1'b0, 1'b1, 11'h008, 5'h01, 2'h0, 16'h0000, 3'h0, 11'h000, 1'b0);
    settle();
    `CHK("error", 1'b1, o_transmitter_error_flag)
    clear_err();
    for (int j = 0; j < 16; j++) begin
      i_tx_checksum_engine_on = j[3];
      u_host.buffer(1'b1, 1'b1, 11'h001, 5'h00, 2'h0, 16'(j), j[2:0], 11'h001, 1'b0);
      settle();
      `CHK("checksum", j[2] & j[3], o_tx_checksum_request)
      `CHK("crc", ~j[1] | j[0], o_crc_append)
      `CHK("pad", ~j[0], o_pad_enable)
      `CHK("tag", 16'(j), o_pkt_tag)
    end
    `CHK("error", 1'b0, o_transmitter_error_flag)
    // a non-first buffer with no packet open, end alignment code 3 taken as 4 bytes
    u_host.buffer(1'b0, 1'b1, 11'h002, 5'h01, 2'h3, 16'h0000, 3'h0, 11'h000, 1'b0);
    settle();
    `CHK("error", 1'b1, o_transmitter_error_flag)
    clear_err();
    u_host.buffer(1'b1, 1'b1, 11'h008, 5'h00, 2'h0, 16'h00AA, 3'h0, 11'h008, 1'b1);
    u_host.buffer(1'b1, 1'b1, 11'h002, 5'h02, 2'h0, 16'h00BB, 3'h0, 11'h002, 1'b0);
    settle();
    `CHK("error", 1'b1, o_transmitter_error_flag)
    clear_err();
    `CHK("pkt pulses", u_host.fs_count, pkt_pulses)
    give_verdict();
  end
endmodule : testbench
